// ### verilog/lock_defs.vh
// Constants for the program memory lock block: register map,
// field positions, reset values and memory geometry.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef LOCK_DEFS_VH
`define LOCK_DEFS_VH

// ****************************************************************
// Register byte offsets (one aligned 32-bit word each)
// ****************************************************************
`define OFF_LOCK 8'h00
`define OFF_KEY 8'h04
`define OFF_STATUS 8'h08

// ****************************************************************
// Field positions
// ****************************************************************
`define LOCK_ONE_BIT 0
`define LOCK_TWO_BIT 1
`define LOCK_THREE_BIT 2
`define LOCK_LEVEL_LSB 4
`define KEY_DATA_LSB 0
`define KEY_INDEX_LSB 8
`define ST_PROG_REFUSED 0
`define ST_VERIFY_REFUSED 1
`define ST_TABLE_BLOCKED 2
`define ST_EXEC_BLOCKED 3
`define ST_EA_EFFECTIVE 8
`define ST_EA_LATCHED 9
`define ST_BUSY 10
`define ST_KEY_PROGRAMMED 11

// ****************************************************************
// Reset values and geometry
// ****************************************************************
`define LOCK_RESET 3'h0
`define STICKY_RESET 4'h0
`define KEY_ERASED 8'hFF
`define KEY_DEPTH 64
`define KEY_INDEX_W 6
`define CODE_ADDR_W 16
`define INTERNAL_TOP 16'h7FFF
`define REFUSED_DATA 8'h00
`define EA_SETTLE_EDGES 2'h2

`endif

// ### verilog/sync2.v
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input changes slowly compared to the clock.
`timescale 1ns/1ps
`default_nettype none

module sync2 (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Level in and out
  input wire async_in,
  output wire sync_out
);

  reg meta_q; // First stage, read only by the second
  reg sync_q; // Second stage, safe to use

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // sync2

`default_nettype wire

// ### verilog/key_store.v
// Key array of 64 bytes with per-entry erased marks.
// Assumes writes come from the owning lock block on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "lock_defs.vh"

module key_store (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Programming side
  input wire wr_en,
  input wire [5:0] wr_index,
  input wire [7:0] wr_data,
  // Read side
  input wire [5:0] rd_index,
  output wire [7:0] rd_key,
  output wire any_programmed
);

  reg [7:0] mem [0:`KEY_DEPTH-1]; // Stored key bytes
  reg [`KEY_DEPTH-1:0] prog_q; // Set once an entry is programmed
  wire [7:0] old_key; // Current value of the written entry

  // Unprogrammed entries read as erased, no array reset needed
  assign rd_key = prog_q[rd_index] ? mem[rd_index] : `KEY_ERASED;
  assign old_key = prog_q[wr_index] ? mem[wr_index] : `KEY_ERASED;
  assign any_programmed = |prog_q;

  // ****************************************************************
  // Array write: bits can only go from one to zero
  // ****************************************************************
  always @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_index] <= old_key & wr_data;
    end
  end

  // ****************************************************************
  // Programmed marks
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_q <= {`KEY_DEPTH{1'b0}};
    end else if (wr_en) begin
      prog_q[wr_index] <= 1'b1;
    end
  end

endmodule // key_store

`default_nettype wire

// ### verilog/program_memory_lock.v
// Program memory lock: lock levels, key scrambling of code verify,
// programming guard and fetch guard, with an AHB-Lite register slave.
// Assumes code memory reads combinationally on mem_addr, and that
// fetch, verify and programming requests come from hclk logic.
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lock_defs.vh"

// Operation
// - Verify output is code byte XNOR key
// - Erased key bytes read all ones
// - Programming key forces first lock bit
// - No locks: no restrictions, scrambling stays
// - Lock one blocks external table-read internally
// - Lock one latches access select at reset
// - Lock one refuses program memory writes
// - Lock two also disables verify readout
// - Lock three blocks external execution
// - Undefined lock patterns fall to lower level
module program_memory_lock (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  // External access select pin
  input wire external_access_select,
  // Verify request from the programmer
  input wire verify_req,
  input wire [15:0] verify_addr,
  output reg verify_valid,
  output reg verify_refused,
  output reg [7:0] verify_data,
  // Programming request
  input wire prog_req,
  input wire [15:0] prog_addr,
  input wire [7:0] prog_data,
  output reg prog_refused,
  // Code memory port
  output wire [15:0] mem_addr,
  input wire [7:0] mem_rdata,
  output reg mem_we,
  output reg [7:0] mem_wdata,
  // CPU fetch check
  input wire fetch_req,
  input wire [15:0] fetch_addr,
  input wire fetch_code_table_read,
  input wire fetch_pc_external,
  output reg fetch_done,
  output reg fetch_internal,
  output reg fetch_blocked,
  // Status levels
  output wire busy,
  output wire [1:0] lock_level
);

  // ****************************************************************
  // Local states and helpers
  // ****************************************************************
  localparam ST_IDLE = 1'b0; // Waiting for verify or program
  localparam ST_READ = 1'b1; // Verify read in flight

  // Scramble one code byte with its key byte
  function [7:0] scramble;
    input [7:0] code_byte;
    input [7:0] key_byte;
    begin
      scramble = ~(code_byte ^ key_byte);
    end
  endfunction

  // Decode lock bits into a protection level
  function [1:0] decode_level;
    input [2:0] bits;
    begin
      // Patterns outside the four levels fall back
      if (bits[0] && bits[1] && bits[2]) begin
        decode_level = 2'd3;
      end else if (bits[0] && bits[1]) begin
        decode_level = 2'd2;
      end else if (bits[0]) begin
        decode_level = 2'd1;
      end else begin
        decode_level = 2'd0;
      end
    end
  endfunction

  // Address lands in internal code memory
  function is_internal;
    input [15:0] addr;
    input ea_high;
    begin
      is_internal = ea_high && (addr <= `INTERNAL_TOP);
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [2:0] lock_q; // Lock level one, two, three
  reg [3:0] sticky_q; // Refusal and block events
  reg state_q; // Verify state
  reg [15:0] vaddr_q; // Held verify address
  reg armed_q; // Access select already captured
  reg [1:0] settle_q; // Edges since release, until the chain holds the pin
  reg ea_latched_q; // Access select seen at reset release
  reg ap_write_q; // Data phase is a write
  reg [7:0] ap_addr_q; // Data phase offset
  wire ea_sync; // Synchronised access select
  wire ea_effective; // Access select as used by the core
  wire [7:0] key_byte; // Key for the current verify address
  wire key_programmed; // Any key entry programmed
  wire ap_take; // Valid address phase this cycle
  wire key_wr; // Bus write to key register
  wire [3:0] ev; // Events setting sticky bits
  wire ver_take; // Verify accepted this cycle
  wire prg_take; // Program accepted this cycle
  wire [1:0] level; // Current protection level
  wire tbl_block; // Fetch blocked as table read
  wire exe_block; // Fetch blocked as external execution
  wire f_int; // Fetch address is internal

  assign level = decode_level(lock_q);
  assign lock_level = level;

  // ****************************************************************
  // Access select synchroniser and reset-time latch
  // ****************************************************************
  sync2 u_ea_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(external_access_select),
    .sync_out(ea_sync)
  );

  // Capture once the synchroniser holds the pin; before that its
  // stages still show their reset value, not the strap level
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_q <= 2'h0;
      armed_q <= 1'b0;
      ea_latched_q <= 1'b0;
    end else if (!armed_q) begin
      if (settle_q == `EA_SETTLE_EDGES) begin
        // Pin is a strap from here until the next reset
        armed_q <= 1'b1;
        ea_latched_q <= ea_sync;
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // Locked parts ignore later pin changes until the next reset
  assign ea_effective = (lock_q[0] && armed_q) ? ea_latched_q : ea_sync;

  // ****************************************************************
  // Key array, indexed by low address bits
  // ****************************************************************
  key_store u_keys (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(key_wr),
    .wr_index(hwdata[`KEY_INDEX_LSB+5:`KEY_INDEX_LSB]),
    .wr_data(hwdata[`KEY_DATA_LSB+7:`KEY_DATA_LSB]),
    .rd_index(vaddr_q[5:0]),
    .rd_key(key_byte),
    .any_programmed(key_programmed)
  );

  // ****************************************************************
  // AHB-Lite slave: zero wait, always OKAY
  // ****************************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ap_take = hsel && hready && htrans[1];
  // Key writes stop once the second lock bit is set, even with readout still enabled
  assign key_wr = ap_write_q && (ap_addr_q == `OFF_KEY) && !lock_q[1];

  // Address phase capture for the following data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (hready) begin
      ap_write_q <= ap_take && hwrite;
      ap_addr_q <= {haddr[7:2], 2'b00};
    end
  end

  // Read data is built at the address phase, stands in data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
      hrdata <= 32'h00000000;
      case ({haddr[7:2], 2'b00})
        `OFF_LOCK: begin
          hrdata[2:0] <= lock_q;
          hrdata[`LOCK_LEVEL_LSB+1:`LOCK_LEVEL_LSB] <= level;
        end
        `OFF_STATUS: begin
          hrdata[3:0] <= sticky_q;
          hrdata[`ST_EA_EFFECTIVE] <= ea_effective;
          hrdata[`ST_EA_LATCHED] <= ea_latched_q;
          hrdata[`ST_BUSY] <= state_q;
          hrdata[`ST_KEY_PROGRAMMED] <= key_programmed;
        end
        default: begin
          // Key register is write only; unmapped reads zero
          hrdata <= 32'h00000000;
        end
      endcase
    end
  end

  // ****************************************************************
  // Lock bits: set only, never cleared by software
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= `LOCK_RESET;
    end else if (ap_write_q && (ap_addr_q == `OFF_LOCK)) begin
      lock_q <= lock_q | hwdata[2:0];
    end else if (key_wr) begin
      // A programmed key implies the first lock bit
      lock_q[0] <= 1'b1;
    end
  end

  // ****************************************************************
  // Sticky event bits: write one to clear, set wins
  // ****************************************************************
  assign ev = {exe_block, tbl_block, ver_take && lock_q[1] && lock_q[0],
               prg_take && lock_q[0]};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sticky_q <= `STICKY_RESET;
    end else if (ap_write_q && (ap_addr_q == `OFF_STATUS)) begin
      sticky_q <= (sticky_q & ~hwdata[3:0]) | ev;
    end else begin
      sticky_q <= sticky_q | ev;
    end
  end

  // ****************************************************************
  // Verify and programming sequencer
  // ****************************************************************
  // Verify wins when both arrive together; each waits for idle
  assign ver_take = verify_req && (state_q == ST_IDLE);
  assign prg_take = prog_req && !verify_req && (state_q == ST_IDLE);
  assign busy = state_q;
  assign mem_addr = (state_q == ST_READ) ? vaddr_q : prog_addr;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      vaddr_q <= 16'h0000;
      verify_valid <= 1'b0;
      verify_refused <= 1'b0;
      verify_data <= 8'h00;
      prog_refused <= 1'b0;
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      // Pulses default low
      verify_valid <= 1'b0;
      verify_refused <= 1'b0;
      prog_refused <= 1'b0;
      mem_we <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (ver_take) begin
            if (lock_q[0] && lock_q[1]) begin
              // Readout disabled at level two and up
              verify_refused <= 1'b1;
              verify_valid <= 1'b1;
              verify_data <= `REFUSED_DATA;
            end else begin
              vaddr_q <= verify_addr;
              state_q <= ST_READ;
            end
          end else if (prg_take) begin
            if (lock_q[0]) begin
              // No further writes once level one is set
              prog_refused <= 1'b1;
            end else begin
              mem_we <= 1'b1;
              mem_wdata <= prog_data;
            end
          end
        end
        ST_READ: begin
          // Scrambled even with no lock bits set
          verify_data <= scramble(mem_rdata, key_byte);
          verify_valid <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Fetch guard, answer one cycle after the request
  // ****************************************************************
  assign f_int = is_internal(fetch_addr, ea_effective);
  // Table read running outside may not reach inside
  assign tbl_block = fetch_req && lock_q[0] && fetch_code_table_read &&
                     fetch_pc_external && f_int;
  // Opcode fetch from outside at top level
  assign exe_block = fetch_req && (level == 2'd3) &&
                     !fetch_code_table_read && !f_int;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_done <= 1'b0;
      fetch_internal <= 1'b0;
      fetch_blocked <= 1'b0;
    end else begin
      fetch_done <= fetch_req;
      fetch_internal <= fetch_req && f_int;
      fetch_blocked <= tbl_block || exe_block;
    end
  end

endmodule // program_memory_lock

`default_nettype wire

// ### testbench/code_mem_model.sv
// Partner model: code memory behind the lock block's memory port.
// Assumes reads are combinational on mem_addr and writes land on hclk.
`timescale 1ns/1ps
`default_nettype none
module code_mem_model (
  // Clock
  input wire logic hclk,
  // Memory port
  input wire logic [15:0] mem_addr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  // Only 256 bytes are modelled; the address wraps
  logic [7:0] mem [0:255];
  // Varied fill, never all ones, so verify cannot leak keys
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = ((i * 37 + 11) % 255);
    end
  end
  // Combinational read
  assign mem_rdata = mem[mem_addr[7:0]];
  // Byte write on the pulse
  always @(posedge hclk) begin
    if (mem_we) begin
      mem[mem_addr[7:0]] <= mem_wdata;
    end
  end
endmodule // code_mem_model
`default_nettype wire

// ### testbench/lock_chk.sv
// Checker for the lock block, bound to its ports.
// Assumes one clock domain and the hand-over latencies.
`timescale 1ns/1ps
`default_nettype none
module lock_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Verify
  input wire logic verify_req,
  input wire logic [15:0] verify_addr,
  input wire logic verify_valid,
  input wire logic verify_refused,
  input wire logic [7:0] verify_data,
  // Program
  input wire logic prog_req,
  input wire logic [7:0] prog_data,
  input wire logic prog_refused,
  input wire logic [15:0] mem_addr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  // Fetch
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_code_table_read,
  input wire logic fetch_pc_external,
  input wire logic fetch_done,
  input wire logic fetch_internal,
  input wire logic fetch_blocked,
  // Status
  input wire logic busy,
  input wire logic [1:0] lock_level
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************************************
  // Verify steps
  // ****************************************************************
  // Idle request, so no answer overlaps a new one
  sequence s_vtake; verify_req && !busy && !verify_valid; endsequence
  sequence s_read; busy && mem_addr == $past(verify_addr); endsequence
  sequence s_give; verify_valid && !verify_refused && !busy; endsequence
  // Program request taken when idle
  sequence s_ptake; prog_req && !verify_req && !busy && !verify_valid; endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_verify_open: assert property (s_vtake and lock_level < 2'h2 |=> s_read ##1 s_give)
    else $error("verify answer late or wrong");
  a_verify_shut: assert property (s_vtake and lock_level >= 2'h2 |=>
    verify_valid && verify_refused && verify_data == 8'h00) else $error("verify not refused");
  a_prog_write: assert property (s_ptake and lock_level == 2'h0 |=>
    mem_we && !prog_refused && mem_wdata == $past(prog_data)) else $error("write not done");
  a_prog_refuse: assert property (s_ptake and lock_level != 2'h0 |=>
    prog_refused && !mem_we) else $error("write not refused");
  a_fetch_answer: assert property (fetch_req |=> fetch_done) else $error("fetch not answered");
  a_fetch_upper: assert property (fetch_req && fetch_addr > 16'h7FFF |=>
    !fetch_internal) else $error("upper fetch internal");
  a_table_block: assert property (fetch_req && lock_level != 2'h0 && fetch_code_table_read &&
    fetch_pc_external |=> fetch_blocked == fetch_internal) else $error("table read guard");
  a_exec_block: assert property (fetch_req && lock_level == 2'h3 && !fetch_code_table_read
    |=> fetch_blocked == !fetch_internal) else $error("external execution guard");
  a_free_fetch: assert property (fetch_req && lock_level == 2'h0 |=> !fetch_blocked)
    else $error("blocked with no lock");
endmodule // lock_chk
bind program_memory_lock lock_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp, .verify_req,
  .verify_addr, .verify_valid, .verify_refused, .verify_data, .prog_req, .prog_data,
  .prog_refused, .mem_addr, .mem_we, .mem_wdata, .fetch_req, .fetch_addr,
  .fetch_code_table_read, .fetch_pc_external, .fetch_done, .fetch_internal,
  .fetch_blocked, .busy, .lock_level);
`default_nettype wire

// ### testbench/program_memory_lock_tb_top.sv
// Testbench for the lock block: bus, verify, program and fetch tasks.
// Assumes hreadyout is the bus hready and the code memory model.
`timescale 1ns/1ps
`default_nettype none
module program_memory_lock_tb_top;
  // Driven inputs
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ea_pin = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic verify_req = 1'b0, prog_req = 1'b0, fetch_req = 1'b0, tbl = 1'b0, pcx = 1'b0, vr;
  logic [15:0] verify_addr = 16'h0, prog_addr = 16'h0, fetch_addr = 16'h0;
  logic [7:0] prog_data = 8'h00, vd;
  // Observed outputs
  wire logic hready, hreadyout, hresp, verify_valid, verify_refused, prog_refused, mem_we;
  wire logic fetch_done, fetch_internal, fetch_blocked, busy;
  wire logic [31:0] hrdata;
  wire logic [15:0] mem_addr;
  wire logic [7:0] mem_rdata, verify_data, mem_wdata;
  wire logic [1:0] lock_level;
  int fails = 0, cmp_count = 0;
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  program_memory_lock i_program_memory_lock (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .external_access_select(ea_pin),
    .verify_req, .verify_addr, .verify_valid, .verify_refused, .verify_data, .prog_req,
    .prog_addr, .prog_data, .prog_refused, .mem_addr, .mem_rdata, .mem_we, .mem_wdata,
    .fetch_req, .fetch_addr, .fetch_code_table_read(tbl), .fetch_pc_external(pcx),
    .fetch_done, .fetch_internal, .fetch_blocked, .busy, .lock_level);
  code_mem_model u_mem (.hclk, .mem_addr, .mem_we, .mem_wdata, .mem_rdata);
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for hready at the next edges
  task wait_rdy;
    int n;
    @(posedge hclk);
    for (n = 0; n < 16 && hready !== 1'b1; n++) @(posedge hclk);
    if (hready !== 1'b1) begin
      fails++;
      wrap_up;
    end
  endtask
  // One single word transfer; read data lands in rd
  task bus(input logic wr, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  // Verify read; answer waits are bounded
  task ver(input logic [15:0] a);
    int n;
    @(posedge hclk);
    verify_req <= 1'b1;
    verify_addr <= a;
    // A refused answer stands in the cycle right after the take edge
    for (n = 0; n < 8; n++) begin
      @(posedge hclk);
      verify_req <= 1'b0;
      #1;
      if (verify_valid === 1'b1) break;
    end
    if (verify_valid !== 1'b1) begin
      fails++;
      wrap_up;
    end
    vd = verify_data;
    vr = verify_refused;
  endtask
  // Fetch check; address held one cycle past the request
  task fet(input logic [15:0] a, input logic t, x, ei, eb);
    @(posedge hclk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    tbl <= t;
    pcx <= x;
    @(posedge hclk);
    fetch_req <= 1'b0;
    #1;
    check("fetch_done", 1, fetch_done);
    check("fetch_internal", ei, fetch_internal);
    check("fetch_blocked", eb, fetch_blocked);
  endtask
  task prg(input logic [15:0] a, input logic [7:0] d, input logic er);
    @(posedge hclk);
    prog_req <= 1'b1;
    prog_addr <= a;
    prog_data <= d;
    @(posedge hclk);
    prog_req <= 1'b0;
    #1;
    check("prog_refused", er, prog_refused);
    check("mem_we", !er, mem_we);
    @(posedge hclk);
  endtask
  // Pin change, then let the synchroniser settle
  task pin(input logic v);
    @(posedge hclk);
    ea_pin <= v;
    repeat (4) @(posedge hclk);
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 32'h0, 0); check("lock", 0, rd);
    bus(0, 32'h8, 0); check("status", 32'h100, rd & 32'hDFF);
    bus(0, 32'h4, 0); check("key", 0, rd);
    bus(0, 32'hC, 0); check("unmapped", 0, rd);
    prg(16'h0005, 8'h3C, 0);
    ver(16'h0005); check("verify", 8'h3C, vd);
    fet(16'h0100, 1, 1, 1, 0);
    pin(0);
    fet(16'h0100, 1, 1, 0, 0);
    pin(1);
    bus(1, 32'h4, 32'h35A);
    bus(0, 32'h0, 0); check("lock", 32'h11, rd);
    bus(0, 32'h8, 0); check("status", 32'h900, rd & 32'hDFF);
    ver(16'h0043); check("verify", {24'h0, ~(u_mem.mem[8'h43] ^ 8'h5A)}, vd);
    ver(16'h0044); check("verify", u_mem.mem[8'h44], vd);
    prg(16'h0006, 8'h11, 1);
    bus(0, 32'h8, 0); check("status", 32'h901, rd & 32'hDFF);
    bus(1, 32'h8, 32'h1);
    bus(0, 32'h8, 0); check("status", 32'h900, rd & 32'hDFF);
    fet(16'h0100, 1, 1, 1, 1);
    fet(16'h8000, 1, 1, 0, 0);
    fet(16'h0100, 1, 0, 1, 0);
    pin(0);
    fet(16'h0100, 0, 0, 1, 0);
    bus(0, 32'h8, 0); check("ea_effective", 1, rd[8]);
    pin(1);
    bus(1, 32'h0, 32'h2);
    bus(0, 32'h0, 0); check("lock", 32'h23, rd);
    ver(16'h0043); check("refused", 1, vr);
    check("verify", 0, vd);
    bus(1, 32'h0, 32'h4);
    bus(0, 32'h0, 0); check("lock", 32'h37, rd);
    fet(16'h9000, 0, 1, 0, 1);
    fet(16'h0100, 0, 1, 1, 0);
    // Second reset clears the volatile lock state
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1, 32'h0, 32'h2);
    bus(0, 32'h0, 0); check("lock", 32'h2, rd);
    check("lock_level", 0, lock_level);
    ver(16'h0044); check("refused", 0, vr);
    wrap_up;
  end
endmodule // program_memory_lock_tb_top
`default_nettype wire
